// File: core/prt_capture_channel.sv
// One input capture channel with its pending flag
`timescale 1ns/1ps
`include "prt_defines.svh"
module prt_capture_channel import prt_pkg::*; (
	input  wire logic                  ref_clk,  // Timer clock
	input  wire logic                  rst_b,    // Async reset, active low
	input  wire logic                  capPin,   // Capture input pin
	input  wire logic                  edgeSel,  // 1 rising, 0 falling
	input  wire logic [`PRT_CNT_W-1:0] counter,  // Live counter
	input  wire logic                  readClr,  // Software reads value
	output logic [`PRT_CNT_W-1:0]      capValue, // Captured counter
	output logic                       capFlag   // Capture pending
);
	prt_cap_state_s r, n; // Current and next state
	logic           edgeHit; // Active edge this cycle

	// Edge detect, latch and flag
	always_comb begin
		n = r;
		n.pinPrev = capPin;
		edgeHit = edgeSel ? (capPin & ~r.pinPrev) : (~capPin & r.pinPrev);
		// A read in the same cycle frees the latch, so the edge is kept
		if (edgeHit && (!r.flag || readClr)) begin
			n.value = counter;
			n.flag = 1'b1;
		end else if (readClr) begin
			n.flag = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			r <= '0;
		else
			r <= n;
	end

	assign capValue = r.value;
	assign capFlag  = r.flag;
endmodule // prt_capture_channel

// File: core/prt_defines.svh
// Register offsets, field positions, reset values and widths of the reload timer
`ifndef PRT_DEFINES_SVH
`define PRT_DEFINES_SVH

`define PRT_ADDR_W      8
`define PRT_CNT_W       8
`define PRT_PRE_W       7
`define PRT_NUM_PWM     4
`define PRT_NUM_CAP     2
`define PRT_OFS_CSR     8'h00
`define PRT_OFS_CAR     8'h04
`define PRT_OFS_ARR     8'h08
`define PRT_OFS_PWM_OUTPUT_CTRL_REG   8'h0c
`define PRT_OFS_DCR0    8'h10
`define PRT_OFS_DCR3    8'h1c
`define PRT_OFS_ICCSR   8'h20
`define PRT_OFS_ICR0    8'h24
`define PRT_OFS_ICR1    8'h28
`define PRT_CSR_CLOCK_SOURCE_SELECT    7
`define PRT_CSR_CC_HI   6
`define PRT_CSR_CC_LO   4
`define PRT_CSR_TCE     3
`define PRT_CSR_FORCE_RELOAD    2
`define PRT_CSR_OIE     1
`define PRT_CSR_OVF     0
`define PRT_PWM_OUTPUT_CTRL_REG_OE_LO 4
`define PRT_ICCSR_CS_LO 4
`define PRT_ICCSR_IE_LO 2
`define PRT_RST_BYTE    8'h00
`define PRT_RST_WORD    32'h0000_0000
`define PRT_CNT_MAX     8'hff
`define PRT_CNT_ONE     8'h01
`define PRT_PRE_ONE     7'h01
`define PRT_TAP_ONE     8'h01

`endif

// File: core/prt_pkg.sv
// Types shared by the reload timer modules
package prt_pkg;
`include "prt_defines.svh"

	// Whole state of the timer top
	typedef struct packed {
		logic                                    clkSel;   // External clock chosen
		logic [2:0]                              divSel;   // Prescaler tap
		logic                                    run;      // Counter running
		logic                                    ovfIe;    // Overflow irq enable
		logic                                    ovfFlag;  // Overflow seen
		logic [`PRT_CNT_W-1:0]                   counter;  // Live counter
		logic [`PRT_PRE_W-1:0]                   presc;    // Prescaler
		logic [`PRT_CNT_W-1:0]                   reload;   // Reload value
		logic [`PRT_NUM_PWM-1:0]                 outEn;    // Pin enables
		logic [`PRT_NUM_PWM-1:0]                 outPol;   // Pin polarities
		logic [`PRT_NUM_PWM-1:0][`PRT_CNT_W-1:0] duty;     // Duty buffers
		logic [`PRT_NUM_CAP-1:0]                 capEdge;  // 1 rising, 0 falling
		logic [`PRT_NUM_CAP-1:0]                 capIe;    // Capture irq enables
		logic                                    extPrev;  // Last external clock level
		logic [31:0]                             rdData;   // Read data latch
	} prt_state_s;

	// State of one PWM channel
	typedef struct packed {
		logic [`PRT_CNT_W-1:0] activeCmp; // Hidden compare value
		logic                  wave;      // Raw waveform before polarity
		logic                  pin;       // Registered pin level
	} prt_pwm_state_s;

	// State of one capture channel
	typedef struct packed {
		logic [`PRT_CNT_W-1:0] value;   // Captured counter
		logic                  flag;    // Capture pending
		logic                  pinPrev; // Last pin level
	} prt_cap_state_s;
endpackage

// File: core/prt_pwm_channel.sv
// One PWM channel: hidden compare buffer and waveform
`timescale 1ns/1ps
`include "prt_defines.svh"
module prt_pwm_channel import prt_pkg::*; (
	input  wire logic                  ref_clk,  // Timer clock
	input  wire logic                  rst_b,    // Async reset, active low
	input  wire logic [`PRT_CNT_W-1:0] duty,     // Software duty buffer
	input  wire logic [`PRT_CNT_W-1:0] counter,  // Live counter
	input  wire logic                  cntTick,  // Counter advances
	input  wire logic                  overflow, // Counter wraps
	input  wire logic                  halted,   // Chip in halt
	input  wire logic                  outPol,   // Polarity bit
	input  wire logic                  outEn,    // Output enable bit
	output logic                       pwmPin    // Pin level
);
	prt_pwm_state_s r, n; // Current and next state

	// Compare and waveform
	always_comb begin
		n = r;
		if (overflow) begin
			n.activeCmp = duty;
			// Waveform frozen in halt; counting may still go on
			if (!halted)
				n.wave = 1'b1;
		end else if (cntTick && counter == r.activeCmp && !halted) begin
			n.wave = 1'b0;
		end
		// Polarity applied after the waveform so a flip acts at once
		n.pin = outEn & (n.wave ^ outPol);
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			r <= '0;
		else
			r <= n;
	end

	assign pwmPin = r.pin;
endmodule // prt_pwm_channel

// File: core/prt_timer_top.sv
// Auto-reload PWM timer with prescaler, captures and APB registers
`timescale 1ns/1ps
`include "prt_defines.svh"
module prt_timer_top import prt_pkg::*; (
	input  wire logic                    ref_clk,      // Timer clock, 125 MHz
	input  wire logic                    rst_b,        // Async reset, active low
	input  wire logic                    psel,         // APB select
	input  wire logic                    penable,      // APB access phase
	input  wire logic                    pwrite,       // APB write
	input  wire logic [`PRT_ADDR_W-1:0]  paddr,        // APB byte address
	input  wire logic [31:0]             pwdata,       // APB write data
	output logic [31:0]                  prdata,       // APB read data
	output logic                         pready,       // APB ready
	output logic                         pslverr,      // APB error
	input  wire logic                    extClkIn,     // External clock or events
	input  wire logic [`PRT_NUM_CAP-1:0] captureIn,    // Capture input pins
	input  wire logic                    chipHalt,     // Chip in halt mode
	output logic [`PRT_NUM_PWM-1:0]      pwmPin,       // PWM pin levels
	output logic [`PRT_NUM_PWM-1:0]      pwmPinOe,     // PWM pin drive enables
	output logic                         overflowIrq,  // Overflow irq request
	output logic [`PRT_NUM_CAP-1:0]      captureIrq,   // Capture irq requests
	output logic                         wakeUp        // Wake request in halt
);
	prt_state_s                          r;          // Registered state
	prt_state_s                          n;          // Next state
	logic                                inTick;     // Input clock tick
	logic                                cpuFrozen;  // Cpu clock stopped by halt
	logic [`PRT_PRE_W-1:0]               tapMask;    // Low prescaler bits for tap
	logic                                tapHit;     // Prescaler at tap
	logic                                preTick;    // Prescaler steps
	logic                                cntTick;    // Counter steps
	logic                                overflow;   // Counter wraps
	logic                                setup;      // APB setup cycle
	logic                                rdSetup;    // Read in setup cycle
	logic                                wrAccess;   // Write completes
	logic                                mapped;     // Address decodes
	logic [`PRT_NUM_CAP-1:0]             capRead;    // Capture value read
	logic [`PRT_NUM_CAP-1:0]             capFlag;    // Capture flags
	logic [`PRT_NUM_CAP-1:0][`PRT_CNT_W-1:0] capValue; // Capture values
	logic [`PRT_NUM_PWM-1:0]             pwmLevel;   // Channel levels

	// Bus phases; side effects of a read happen at setup, with the data latch
	assign setup    = psel & ~penable;
	assign rdSetup  = setup & ~pwrite;
	assign wrAccess = psel & penable & pwrite;

	// Address decode for error reporting
	always_comb begin
		if (paddr == `PRT_OFS_CSR)
			mapped = 1'b1;
		else if (paddr == `PRT_OFS_CAR)
			mapped = 1'b1;
		else if (paddr == `PRT_OFS_ARR)
			mapped = 1'b1;
		else if (paddr == `PRT_OFS_PWM_OUTPUT_CTRL_REG)
			mapped = 1'b1;
		else if (paddr >= `PRT_OFS_DCR0 && paddr <= `PRT_OFS_DCR3 && paddr[1:0] == 2'b00)
			mapped = 1'b1;
		else if (paddr == `PRT_OFS_ICCSR)
			mapped = 1'b1;
		else if (paddr == `PRT_OFS_ICR0)
			mapped = 1'b1;
		else if (paddr == `PRT_OFS_ICR1)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

	// Reading a capture value frees its latch
	assign capRead[0] = rdSetup && paddr == `PRT_OFS_ICR0;
	assign capRead[1] = rdSetup && paddr == `PRT_OFS_ICR1;

	// Clock source, prescaler tap and counter tick
	always_comb begin
		// External clock counts its rising edges; cpu clock ticks every cycle
		inTick = r.clkSel ? (extClkIn & ~r.extPrev) : 1'b1;
		// In halt the cpu clock is gone, the external one keeps going
		cpuFrozen = chipHalt & ~r.clkSel;
		tapMask = `PRT_PRE_W'((`PRT_TAP_ONE << r.divSel) - `PRT_TAP_ONE);
		tapHit = (r.presc & tapMask) == tapMask;
		preTick = r.run & inTick & ~cpuFrozen;
		cntTick = preTick & tapHit;
		overflow = cntTick && r.counter == `PRT_CNT_MAX;
	end

	// Next state: counting, then bus writes, then read side effects
	always_comb begin
		n = r;
		n.extPrev = extClkIn;
		// Prescaler free runs through the taps
		if (preTick)
			n.presc = `PRT_PRE_W'(r.presc + `PRT_PRE_ONE);
		// Counter steps; wrap reloads so the period is 256 minus reload
		if (cntTick) begin
			if (overflow)
				n.counter = r.reload;
			else
				n.counter = `PRT_CNT_W'(r.counter + `PRT_CNT_ONE);
		end
		// Writes are ignored in halt: no register takes a bus write
		if (wrAccess && !chipHalt) begin
			if (paddr == `PRT_OFS_CSR) begin
				n.clkSel = pwdata[`PRT_CSR_CLOCK_SOURCE_SELECT];
				n.divSel = pwdata[`PRT_CSR_CC_HI:`PRT_CSR_CC_LO];
				n.run = pwdata[`PRT_CSR_TCE];
				n.ovfIe = pwdata[`PRT_CSR_OIE];
				// Force reload is a one-shot action, never stored
				if (pwdata[`PRT_CSR_FORCE_RELOAD]) begin
					n.counter = r.reload;
					n.presc = '0;
				end
			end else if (paddr == `PRT_OFS_CAR) begin
				// Software write wins over a tick in the same cycle
				n.counter = pwdata[`PRT_CNT_W-1:0];
				n.presc = '0;
			end else if (paddr == `PRT_OFS_ARR) begin
				n.reload = pwdata[`PRT_CNT_W-1:0];
			end else if (paddr == `PRT_OFS_PWM_OUTPUT_CTRL_REG) begin
				n.outEn = pwdata[`PRT_PWM_OUTPUT_CTRL_REG_OE_LO+`PRT_NUM_PWM-1:`PRT_PWM_OUTPUT_CTRL_REG_OE_LO];
				n.outPol = pwdata[`PRT_NUM_PWM-1:0];
			end else if (paddr >= `PRT_OFS_DCR0 && paddr <= `PRT_OFS_DCR3 && paddr[1:0] == 2'b00) begin
				n.duty[paddr[3:2]] = pwdata[`PRT_CNT_W-1:0];
			end else if (paddr == `PRT_OFS_ICCSR) begin
				n.capEdge = pwdata[`PRT_ICCSR_CS_LO+`PRT_NUM_CAP-1:`PRT_ICCSR_CS_LO];
				n.capIe = pwdata[`PRT_ICCSR_IE_LO+`PRT_NUM_CAP-1:`PRT_ICCSR_IE_LO];
			end
		end
		// Read data latch; unmapped reads give zero
		if (rdSetup) begin
			n.rdData = `PRT_RST_WORD;
			if (paddr == `PRT_OFS_CSR) begin
				// Force reload bit always reads zero
				n.rdData[`PRT_CNT_W-1:0] = {r.clkSel, r.divSel, r.run, 1'b0, r.ovfIe, r.ovfFlag};
			end else if (paddr == `PRT_OFS_CAR) begin
				n.rdData[`PRT_CNT_W-1:0] = r.counter;
			end else if (paddr == `PRT_OFS_ARR) begin
				n.rdData[`PRT_CNT_W-1:0] = r.reload;
			end else if (paddr == `PRT_OFS_PWM_OUTPUT_CTRL_REG) begin
				n.rdData[`PRT_CNT_W-1:0] = {r.outEn, r.outPol};
			end else if (paddr >= `PRT_OFS_DCR0 && paddr <= `PRT_OFS_DCR3 && paddr[1:0] == 2'b00) begin
				n.rdData[`PRT_CNT_W-1:0] = r.duty[paddr[3:2]];
			end else if (paddr == `PRT_OFS_ICCSR) begin
				// Top two bits are reserved and read zero
				n.rdData[`PRT_CNT_W-1:0] = {2'b00, r.capEdge, r.capIe, capFlag};
			end else if (paddr == `PRT_OFS_ICR0) begin
				n.rdData[`PRT_CNT_W-1:0] = capValue[0];
			end else if (paddr == `PRT_OFS_ICR1) begin
				n.rdData[`PRT_CNT_W-1:0] = capValue[1];
			end
		end
		// Read clears overflow flag; a new overflow in that cycle wins
		if (rdSetup && paddr == `PRT_OFS_CSR)
			n.ovfFlag = 1'b0;
		if (overflow)
			n.ovfFlag = 1'b1;
	end

	// State register; reset clears counter, prescaler and clock select
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			r <= '0;
		else
			r <= n;
	end

	// PWM channels share counter and overflow
	genvar gi;
	generate
		for (gi = 0; gi < `PRT_NUM_PWM; gi++) begin : g_pwm
			prt_pwm_channel u_pwm (
				.ref_clk  (ref_clk),
				.rst_b    (rst_b),
				.duty     (r.duty[gi]),
				.counter  (r.counter),
				.cntTick  (cntTick),
				.overflow (overflow),
				.halted   (chipHalt),
				.outPol   (r.outPol[gi]),
				.outEn    (r.outEn[gi]),
				.pwmPin   (pwmLevel[gi])
			);
		end
		// Capture channels latch the live counter
		for (gi = 0; gi < `PRT_NUM_CAP; gi++) begin : g_cap
			prt_capture_channel u_cap (
				.ref_clk  (ref_clk),
				.rst_b    (rst_b),
				.capPin   (captureIn[gi]),
				.edgeSel  (r.capEdge[gi]),
				.counter  (r.counter),
				.readClr  (capRead[gi]),
				.capValue (capValue[gi]),
				.capFlag  (capFlag[gi])
			);
		end
	endgenerate

	// Pins and requests
	assign pwmPin      = pwmLevel;
	assign pwmPinOe    = r.outEn;
	assign overflowIrq = r.ovfFlag & r.ovfIe;
	assign captureIrq  = capFlag & r.capIe;
	// Any enabled request pulls the chip out of halt
	assign wakeUp      = chipHalt & (overflowIrq | (|captureIrq));

	// Bus answers at once; data comes from the latch filled at setup
	assign prdata  = r.rdData;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
endmodule // prt_timer_top

// File: verification/prt_far_side.sv
// Far-side model: event source and capture signal drivers
`timescale 1ns/1ps
module prt_far_side (
	input  wire logic       ref_clk,   // Timer clock
	input  wire logic       rst_b,     // Reset, active low
	input  wire logic       evtGo,     // Start a burst
	input  wire logic [7:0] evtNum,    // Events in burst
	input  wire logic [3:0] evtGap,    // Extra cycles per half event
	input  wire logic [1:0] capLvl,    // Wanted capture levels
	output logic            extClkIn,  // Event line
	output logic [1:0]      captureIn, // Capture lines
	output logic            evtBusy    // Burst running
);
	logic [7:0] leftCnt; // Events still owed
	logic [3:0] phase;   // Cycles spent in this half
	assign evtBusy = (leftCnt != 8'h00);
	// Burst engine; a gap of zero is the fastest the timer can see
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			leftCnt <= 8'h00;
			phase <= 4'h0;
			extClkIn <= 1'b0;
			captureIn <= 2'b00;
		end else begin
			captureIn <= capLvl;
			if (evtGo && !evtBusy) begin
				leftCnt <= evtNum;
				phase <= 4'h0;
			end else if (evtBusy) begin
				if (phase == evtGap) begin
					phase <= 4'h0;
					extClkIn <= !extClkIn;
					// Event complete once the line falls again
					if (extClkIn) begin
						leftCnt <= leftCnt - 8'h01;
					end
				end else begin
					phase <= phase + 4'h1;
				end
			end
		end
	end
endmodule // prt_far_side

// File: verification/prt_timer_checker.sv
// Port-level assertions for the reload timer
`timescale 1ns/1ps
`include "prt_defines.svh"
module prt_timer_checker import prt_pkg::*; (
	input wire logic                    ref_clk,     // Timer clock
	input wire logic                    rst_b,       // Reset, active low
	input wire logic                    psel,        // APB select
	input wire logic                    penable,     // APB access phase
	input wire logic                    pwrite,      // APB write
	input wire logic [`PRT_ADDR_W-1:0]  paddr,       // APB address
	input wire logic [31:0]             pwdata,      // APB write data
	input wire logic [31:0]             prdata,      // APB read data
	input wire logic                    pslverr,     // APB error
	input wire logic                    chipHalt,    // Chip halted
	input wire logic [`PRT_NUM_PWM-1:0] pwmPin,      // PWM levels
	input wire logic [`PRT_NUM_PWM-1:0] pwmPinOe,    // PWM drive enables
	input wire logic                    overflowIrq, // Overflow request
	input wire logic [`PRT_NUM_CAP-1:0] captureIrq,  // Capture requests
	input wire logic                    wakeUp       // Wake request
);
	// Read setup and write access phases
	wire rdSet = psel && !penable && !pwrite;
	wire wrAcc = psel && penable && pwrite;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_wake_from_irq: assert property (wakeUp == (chipHalt && (overflowIrq || |captureIrq)))
		else $error("wake request does not follow halt and requests");
	a_pin_needs_oe: assert property ((pwmPin & ~pwmPinOe) == 4'h0)
		else $error("pin high while its drive is off");
	a_oe_follows_write: assert property (wrAcc && paddr == `PRT_OFS_PWM_OUTPUT_CTRL_REG && !chipHalt
		|=> pwmPinOe == $past(pwdata[7:4])) else $error("drive enables miss the written value");
	a_ovf_irq_holds: assert property (overflowIrq && !(rdSet && paddr == `PRT_OFS_CSR)
		&& !(wrAcc && paddr == `PRT_OFS_CSR) |=> overflowIrq) else $error("overflow request dropped");
	a_cap_irq_holds: assert property (captureIrq[0] && !(rdSet && paddr == `PRT_OFS_ICR0)
		&& !(wrAcc && paddr == `PRT_OFS_ICCSR) |=> captureIrq[0]) else $error("capture request dropped");
	a_force_reads_zero: assert property (rdSet && paddr == `PRT_OFS_CSR
		|=> prdata[`PRT_CSR_FORCE_RELOAD] == 1'b0 && prdata[31:8] == 24'h0) else $error("reload bit read as one");
	a_halt_pins_frozen: assert property (chipHalt [*3] |=> $stable(pwmPin))
		else $error("pins moved in halt");
	a_map_error: assert property (psel && penable
		|-> pslverr == (paddr > `PRT_OFS_ICR1 || paddr[1:0] != 2'b00)) else $error("error flag wrong");
endmodule // prt_timer_checker

bind prt_timer_top prt_timer_checker chk_u (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pslverr, .chipHalt, .pwmPin, .pwmPinOe, .overflowIrq, .captureIrq, .wakeUp);

// File: verification/testbench.sv
// Self-checking bench for the reload timer
`timescale 1ns/1ps
`include "prt_defines.svh"
module testbench;
	typedef struct { string nm; logic [31:0] exp; logic [31:0] msk; } prt_note_s;
	logic        ref_clk, rst_b, psel, penable, pwrite, chipHalt, evtGo, snapReq;
	logic        pready, pslverr, extClkIn, overflowIrq, wakeUp, evtBusy;
	logic [7:0]  paddr, evtNum, a;
	logic [7:0]  hiCnt = 8'h00; // Ch0 high cycles since last snapshot
	logic [31:0] pwdata, prdata, d;
	logic [3:0]  evtGap, pwmPin, pwmPinOe;
	logic [1:0]  capLvl, captureIn, captureIrq;
	int          failures, checkCount;
	integer      seed;
	prt_note_s   notes[$]; // Expected results, oldest first

	prt_timer_top dut_u (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .extClkIn, .captureIn, .chipHalt, .pwmPin, .pwmPinOe, .overflowIrq, .captureIrq, .wakeUp);
	prt_far_side far_u (.ref_clk, .rst_b, .evtGo, .evtNum, .evtGap, .capLvl, .extClkIn, .captureIn, .evtBusy);

	// 125 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish;
		if (failures == 0 && checkCount > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic compare(input logic [31:0] seen);
		prt_note_s n;
		n = notes.pop_front();
		checkCount++;
		if (((seen ^ n.exp) & n.msk) !== 32'h0) begin
			failures++;
			$display("BAD %s expected %h seen %h", n.nm, n.exp & n.msk, seen & n.msk);
		end
	endtask

	// Watcher: completed reads and snapshots; error flag rides in bit 31
	always @(posedge ref_clk) begin
		if (psel && penable && pready && !pwrite) begin
			compare({pslverr, prdata[30:0]});
		end
		if (snapReq) begin
			compare({12'h000, hiCnt, captureIrq, overflowIrq, wakeUp, pwmPinOe, pwmPin});
			hiCnt = 8'h00;
		end
		hiCnt = hiCnt + {7'h00, pwmPin[0]};
	end

	// One APB transfer; the leading edge keeps transfers apart
	task automatic apb(input logic isWr, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= isWr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		apb(1'b1, ad, wd);
	endtask

	task automatic rd(input string nm, input logic [7:0] ad, input logic [31:0] e);
		notes.push_back('{nm, e, 32'hffff_ffff});
		apb(1'b0, ad, 32'h0);
	endtask

	task automatic snap(input string nm, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{nm, e, m});
		@(posedge ref_clk);
		snapReq <= 1'b1;
		@(posedge ref_clk);
		snapReq <= 1'b0;
	endtask

	task automatic burst(input logic [7:0] num, input logic [3:0] gap);
		@(posedge ref_clk);
		evtNum <= num;
		evtGap <= gap;
		evtGo <= 1'b1;
		@(posedge ref_clk);
		evtGo <= 1'b0;
		@(posedge ref_clk);
		while (evtBusy === 1'b1) @(posedge ref_clk);
	endtask

	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
	endtask

	// Hang guard, far beyond the expected run of under two thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		tally_and_finish;
	end

	initial begin
		seed = 32'h30bc344a;
		{rst_b, psel, penable, pwrite, chipHalt, evtGo, snapReq} = 7'h00;
		{paddr, evtNum, evtGap, capLvl} = 22'h0;
		pwdata = 32'h0;
		do_reset;
		for (int i = 0; i <= 10; i++) rd("reset", 8'(4 * i), 32'h0);
		rd("unmapped", 8'h30, 32'h8000_0000);
		// Random words; reload value written last
		for (int i = 0; i < 5; i++) begin
			d = $random(seed);
			a = (i == 4) ? `PRT_OFS_ARR : 8'(`PRT_OFS_DCR0 + 4 * i);
			wr(a, d);
			rd("readback", a, {24'h0, d[7:0]});
		end
		wr(`PRT_OFS_CSR, 32'h06);
		rd("csr", `PRT_OFS_CSR, 32'h02);
		rd("forced", `PRT_OFS_CAR, {24'h0, d[7:0]});
		// Run exactly three counts per tap, then stop
		for (int n = 0; n < 8; n++) begin
			wr(`PRT_OFS_CSR, 32'(n << 4));
			wr(`PRT_OFS_CAR, 32'h20);
			wr(`PRT_OFS_CSR, 32'((n << 4) | 8'h08));
			repeat ((3 << n) - 3) @(posedge ref_clk);
			wr(`PRT_OFS_CSR, 32'(n << 4));
			rd("count", `PRT_OFS_CAR, 32'h23);
			rd("held", `PRT_OFS_CAR, 32'h23);
		end
		do_reset;
		// External events, three to overflow
		wr(`PRT_OFS_ARR, 32'hfd);
		wr(`PRT_OFS_CSR, 32'h8c);
		burst(8'h02, 4'h0);
		rd("events", `PRT_OFS_CAR, 32'hff);
		rd("no flag", `PRT_OFS_CSR, 32'h88);
		burst(8'h01, 4'h2);
		rd("reloaded", `PRT_OFS_CAR, 32'hfd);
		rd("flag", `PRT_OFS_CSR, 32'h89);
		rd("cleared", `PRT_OFS_CSR, 32'h88);
		wr(`PRT_OFS_CSR, 32'h8a);
		chipHalt <= 1'b1;
		burst(8'h03, 4'h1);
		snap("halt wake", 32'h300, 32'hf00);
		wr(`PRT_OFS_ARR, 32'h10);
		chipHalt <= 1'b0;
		rd("frozen", `PRT_OFS_ARR, 32'hfd);
		do_reset;
		// Period of eight counts, ch0 duty ends at fc
		wr(`PRT_OFS_ARR, 32'hf8);
		for (int c = 0; c < 4; c++) wr(8'(`PRT_OFS_DCR0 + 4 * c), 32'hfc);
		wr(`PRT_OFS_PWM_OUTPUT_CTRL_REG, 32'hf0);
		wr(`PRT_OFS_CSR, 32'h0c);
		repeat (16) @(posedge ref_clk);
		snap("drives", 32'h0f0, 32'h0f0);
		repeat (62) @(posedge ref_clk);
		snap("high", 32'h28000, 32'hff000);
		wr(`PRT_OFS_PWM_OUTPUT_CTRL_REG, 32'hf1);
		snap("drives", 32'h0f0, 32'h0f0);
		repeat (62) @(posedge ref_clk);
		snap("inverted", 32'h18000, 32'hff000);
		// Halt on cpu clock just after an overflow: every waveform must freeze
		wr(`PRT_OFS_CSR, 32'h0c);
		repeat (8) @(posedge ref_clk);
		chipHalt <= 1'b1;
		snap("halt pins", 32'h0fe, 32'h1ff);
		repeat (20) @(posedge ref_clk);
		snap("halt hold", 32'h000fe, 32'hff1ff);
		chipHalt <= 1'b0;
		do_reset;
		// Captures on a stopped counter
		wr(`PRT_OFS_CAR, 32'h5a);
		wr(`PRT_OFS_ICCSR, 32'h14);
		capLvl <= 2'b11;
		repeat (4) @(posedge ref_clk);
		snap("cap irq", 32'h400, 32'hf00);
		wr(`PRT_OFS_CAR, 32'h33);
		capLvl <= 2'b10;
		repeat (4) @(posedge ref_clk);
		capLvl <= 2'b11;
		repeat (4) @(posedge ref_clk);
		rd("flags", `PRT_OFS_ICCSR, 32'h15);
		rd("first", `PRT_OFS_ICR0, 32'h5a);
		rd("unflagged", `PRT_OFS_ICCSR, 32'h14);
		wr(`PRT_OFS_ICCSR, 32'h08);
		chipHalt <= 1'b1;
		capLvl <= 2'b01;
		repeat (4) @(posedge ref_clk);
		snap("cap wake", 32'h900, 32'hf00);
		chipHalt <= 1'b0;
		rd("ch1", `PRT_OFS_ICR1, 32'h33);
		tally_and_finish;
	end
endmodule // testbench
